//--- logic/tlim_cfg.svh
// Offsets, field positions and reset values of the limit interrupt block
`ifndef TLIM_CFG_SVH
`define TLIM_CFG_SVH

`define TLIM_OFF_STATUS 8'h02
`define TLIM_OFF_MASK 8'h04

`define TLIM_BIT_OS_MODE 7
`define TLIM_BIT_HOT_MODE 6
`define TLIM_BIT_OS_FLAG 5
`define TLIM_BIT_HOT_FLAG 0
`define TLIM_OTHER_LO 1
`define TLIM_OTHER_HI 4
`define TLIM_MASK_HI 5

`define TLIM_MASK_RESET 8'h00
`define TLIM_STATUS_RESET 8'h00
`define TLIM_RDATA_UNMAPPED 8'h00

`endif

//--- logic/tlim_chan.sv
// One temperature comparison: repeating or one-shot status flag
`timescale 1ns/1ps
module tlim_chan (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic conv_done,
    input wire tlim_pkg::tlim_cmp_t cmp,
    input wire logic one_shot,
    input wire logic rd_clr,
    output logic flag
);
    logic active;
    logic next_active;
    logic next_flag;
    logic set_evt;

    always_comb begin
        next_active = active;
        if (conv_done) begin
            if (cmp.over) begin
                next_active = 1'b1;
            end else if (cmp.below_hyst) begin
                next_active = 1'b0;
            end
        end
        set_evt = 1'b0;
        if (conv_done && next_active) begin
            // Repeating: every conversion while active; one-shot: only the crossing
            set_evt = one_shot ? !active : 1'b1;
        end
        next_flag = flag;
        if (rd_clr) begin
            next_flag = 1'b0;
        end
        if (set_evt) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            active <= 1'b0;
            flag <= 1'b0;
        end else begin
            active <= next_active;
            flag <= next_flag;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_rep_reraise: assert property (
        conv_done && !one_shot && cmp.over |=> flag)
        else $error("repeating mode missed an over-limit conversion");

    a_rep_hold_hyst: assert property (
        conv_done && !one_shot && active && !cmp.below_hyst |=> flag)
        else $error("repeating mode stopped above hysteresis");

    a_hyst_disarm: assert property (
        conv_done && !cmp.over && cmp.below_hyst |=> !active)
        else $error("condition not ended below hysteresis");

    a_os_first: assert property (
        conv_done && one_shot && !active && cmp.over |=> flag)
        else $error("one-shot crossing gave no flag");

    a_os_no_repeat: assert property (
        conv_done && one_shot && active && !flag |=> !flag)
        else $error("one-shot flag set again without re-arm");

    a_read_clears: assert property (
        rd_clr && !conv_done |=> !flag)
        else $error("flag survived a clearing read");

    a_set_wins: assert property (
        rd_clr && conv_done && !one_shot && cmp.over |=> flag)
        else $error("set lost against a clearing read");
endmodule

//--- logic/tlim_pkg.sv
// Types shared by the limit interrupt block
package tlim_pkg;

    // Comparison results handed over with each finished conversion
    typedef struct packed {
        logic over;
        logic below_hyst;
    } tlim_cmp_t;

    // One register access from the serial interface
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } tlim_reg_req_t;

endpackage

//--- logic/tlim_top.sv
// Limit interrupt mode select: status, mask and interrupt output
`timescale 1ns/1ps
`include "tlim_cfg.svh"
module tlim_top #(
    parameter int NUM_OTHER = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire tlim_pkg::tlim_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic conv_done,
    input wire tlim_pkg::tlim_cmp_t os_cmp,
    input wire tlim_pkg::tlim_cmp_t hot_cmp,
    input wire logic [NUM_OTHER-1:0] other_evt,
    output logic int_n
);
    // Register hit decode, used for read and write paths
    function automatic logic reg_hit(
        input tlim_pkg::tlim_reg_req_t req,
        input logic [7:0] off
    );
        reg_hit = req.addr == off;
    endfunction

    logic [7:0] limit_irq_mode_mask;
    logic [7:0] next_mask;
    logic [NUM_OTHER-1:0] other_flag;
    logic [NUM_OTHER-1:0] next_other;
    logic [7:0] next_rdata;
    logic next_int_n;
    logic status_rd;
    logic mask_wr;
    logic mask_rd;
    logic overtemp_output_flag;
    logic hot_flag;
    logic [7:0] status_now;
    logic [1:0] chan_flag;
    logic [1:0] chan_mode;

    tlim_pkg::tlim_cmp_t chan_cmp [2];

    assign chan_cmp[0] = hot_cmp;
    assign chan_cmp[1] = os_cmp;
    assign chan_mode[0] = limit_irq_mode_mask[`TLIM_BIT_HOT_MODE];
    assign chan_mode[1] = limit_irq_mode_mask[`TLIM_BIT_OS_MODE];

    // Index 0 is the hot limit, index 1 the overtemp output limit
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            tlim_chan u_chan (
                .ref_clk(ref_clk),
                .rst(rst),
                .conv_done(conv_done),
                .cmp(chan_cmp[gi]),
                .one_shot(chan_mode[gi]),
                .rd_clr(status_rd),
                .flag(chan_flag[gi])
            );
        end
    endgenerate

    assign hot_flag = chan_flag[0];
    assign overtemp_output_flag = chan_flag[1];

    // Register decode
    always_comb begin
        status_rd = reg_req.rd && reg_hit(reg_req, `TLIM_OFF_STATUS);
        mask_rd = reg_req.rd && reg_hit(reg_req, `TLIM_OFF_MASK);
        mask_wr = reg_req.wr && reg_hit(reg_req, `TLIM_OFF_MASK);
    end

    // Status byte as seen by a read
    always_comb begin
        status_now = `TLIM_STATUS_RESET;
        status_now[`TLIM_BIT_OS_FLAG] = overtemp_output_flag;
        status_now[`TLIM_BIT_HOT_FLAG] = hot_flag;
        status_now[`TLIM_OTHER_HI:`TLIM_OTHER_LO] = other_flag;
    end

    // Mask register and other sticky status bits
    always_comb begin
        next_mask = limit_irq_mode_mask;
        if (mask_wr) begin
            next_mask = reg_req.wdata;
        end
        next_other = other_flag;
        if (status_rd) begin
            next_other = '0;
        end
        // A new event in the clearing cycle is kept
        next_other = next_other | other_evt;
    end

    // Read data and interrupt pin
    always_comb begin
        next_rdata = reg_rdata;
        if (status_rd) begin
            next_rdata = status_now;
        end else if (mask_rd) begin
            next_rdata = limit_irq_mode_mask;
        end else if (reg_req.rd) begin
            next_rdata = `TLIM_RDATA_UNMAPPED;
        end
        // Masked flags never reach the pin
        next_int_n = !(|(status_now[`TLIM_MASK_HI:0] &
            ~limit_irq_mode_mask[`TLIM_MASK_HI:0]));
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            limit_irq_mode_mask <= `TLIM_MASK_RESET;
            other_flag <= '0;
            reg_rdata <= `TLIM_RDATA_UNMAPPED;
            int_n <= 1'b1;
        end else begin
            limit_irq_mode_mask <= next_mask;
            other_flag <= next_other;
            reg_rdata <= next_rdata;
            int_n <= next_int_n;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_status_read;
        reg_req.rd && reg_req.addr == `TLIM_OFF_STATUS;
    endsequence

    sequence s_mask_write;
        reg_req.wr && reg_req.addr == `TLIM_OFF_MASK;
    endsequence

    a_mask_store: assert property (
        s_mask_write |=> limit_irq_mode_mask == $past(reg_req.wdata))
        else $error("mask write not stored");

    a_status_layout: assert property (
        s_status_read |=> reg_rdata[`TLIM_BIT_OS_FLAG] ==
            $past(overtemp_output_flag) &&
            reg_rdata[`TLIM_BIT_HOT_FLAG] == $past(hot_flag))
        else $error("status read shows wrong flag positions");

    a_mask_blocks: assert property (
        limit_irq_mode_mask[`TLIM_MASK_HI:0] == 6'h3F &&
            !(reg_req.wr && reg_req.addr == `TLIM_OFF_MASK) |=> int_n)
        else $error("masked flags drove the interrupt");

    a_int_follows: assert property (
        overtemp_output_flag &&
            !limit_irq_mode_mask[`TLIM_BIT_OS_FLAG] |=> !int_n)
        else $error("unmasked overtemp flag gave no interrupt");

    a_os_mode_once: assert property (
        conv_done && limit_irq_mode_mask[`TLIM_BIT_OS_MODE] &&
            !os_cmp.over && !os_cmp.below_hyst &&
            !overtemp_output_flag |=> !overtemp_output_flag)
        else $error("one-shot overtemp flag reappeared");

    a_hot_mode_once: assert property (
        conv_done && limit_irq_mode_mask[`TLIM_BIT_HOT_MODE] &&
            !hot_cmp.over && !hot_cmp.below_hyst && !hot_flag |=> !hot_flag)
        else $error("one-shot hot flag reappeared");
endmodule

//--- verif/tlim_top_tb.sv
// Self-checking bench for the limit interrupt block
`timescale 1ns/1ps
module tlim_top_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    tlim_pkg::tlim_reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    logic conv_done = 1'b0;
    tlim_pkg::tlim_cmp_t os_cmp = '0;
    tlim_pkg::tlim_cmp_t hot_cmp = '0;
    logic [3:0] other_evt = 4'h0;
    logic int_n;
    logic [31:0] seed = 32'h0000A06F;
    int num_errors = 0;
    int total_checks = 0;
    logic [5:0] m_flag;
    logic [1:0] m_act;
    logic [7:0] m_mask;
    logic [7:0] m_rdata;
    logic m_int_n;

    tlim_top #(.NUM_OTHER(4)) tlim_top_inst (
        .ref_clk(ref_clk),
        .rst(rst),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .conv_done(conv_done),
        .os_cmp(os_cmp),
        .hot_cmp(hot_cmp),
        .other_evt(other_evt),
        .int_n(int_n)
    );

    always #5 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Returns new active state and flag set for one comparison
    function automatic logic [1:0] chan(input logic act, input logic os,
                                        input tlim_pkg::tlim_cmp_t c);
        logic a;
        a = c.over | (act & ~c.below_hyst);
        return {a, os ? (a & ~act) : a};
    endfunction

    always @(posedge ref_clk) begin
        logic [1:0] o;
        logic [1:0] h;
        o = chan(m_act[1], m_mask[7], os_cmp);
        h = chan(m_act[0], m_mask[6], hot_cmp);
        if (rst) begin
            m_flag <= 6'h00;
            m_act <= 2'h0;
            m_mask <= 8'h00;
            m_rdata <= 8'h00;
            m_int_n <= 1'b1;
        end else begin
            if (conv_done) m_act <= {o[1], h[1]};
            m_flag <= ((reg_req.rd && reg_req.addr == 8'h02) ? 6'h00 : m_flag)
                | {conv_done & o[0], other_evt, conv_done & h[0]};
            if (reg_req.wr && reg_req.addr == 8'h04) m_mask <= reg_req.wdata;
            if (reg_req.rd) m_rdata <= (reg_req.addr == 8'h02) ?
                {2'h0, m_flag} : (reg_req.addr == 8'h04) ? m_mask : 8'h00;
            m_int_n <= ~|(m_flag & ~m_mask[5:0]);
        end
    end

    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch data at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch pin at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    always @(negedge ref_clk) if (!rst) begin
        chk_data(reg_rdata, m_rdata);
        chk_pin(int_n, m_int_n);
    end

    // One cycle of stimulus: request, conversion, compares, events
    task automatic cyc(input logic [17:0] r, input logic cd,
                       input logic [3:0] c, input logic [3:0] ev);
        reg_req <= r;
        conv_done <= cd;
        os_cmp <= c[3:2];
        hot_cmp <= c[1:0];
        other_evt <= ev;
        @(posedge ref_clk);
    endtask

    task automatic cv(input logic [3:0] c);
        cyc(18'h0, 1'b1, c, 4'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc({a, 2'h2, d}, 1'b0, 4'h0, 4'h0);
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] exp);
        cyc({a, 2'h1, 8'h00}, 1'b0, 4'h0, 4'h0);
        cyc(18'h0, 1'b0, 4'h0, 4'h0);
        chk_data(reg_rdata, exp);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #50000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd_exp(8'h04, 8'h00);
        wr(8'h04, 8'hC0);
        cv(4'hA);
        cv(4'hA);
        rd_exp(8'h02, 8'h21);
        cv(4'hA);
        rd_exp(8'h02, 8'h00);
        cv(4'h5);
        cv(4'hA);
        rd_exp(8'h02, 8'h21);
        wr(8'h04, 8'h00);
        cv(4'hA);
        rd_exp(8'h02, 8'h21);
        cv(4'h0);
        rd_exp(8'h02, 8'h21);
        cv(4'h5);
        cv(4'h0);
        rd_exp(8'h02, 8'h00);
        wr(8'h04, 8'hFF);
        wr(8'h03, 8'h00);
        wr(8'h02, 8'h3F);
        rd_exp(8'h04, 8'hFF);
        rd_exp(8'h07, 8'h00);
        repeat (3000) begin
            seed = xs(seed);
            cyc({5'h00, seed[2:0], seed[3] & seed[4], ~(seed[3] & seed[4])
                & seed[6] & seed[7], seed[15:8]}, seed[16], seed[20:17],
                seed[24:21] & {4{seed[25] & seed[26]}});
        end
        cyc(18'h0, 1'b0, 4'h0, 4'h0);
        repeat (3) @(posedge ref_clk);
        report_and_stop();
    end
endmodule
